// *** pin_sync3.v ***
// Three-stage synchroniser with agreement of the last two stages.
module pin_sync3 (
    input  wire i_core_clk,
    input  wire i_sys_rst,
    input  wire i_pin,
    output reg  o_level,
    output reg  o_rise,
    output reg  o_fall
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // The first stage feeds only the second; a change counts once stages two and three agree.
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            o_level <= 1'b0;
            o_rise  <= 1'b0;
            o_fall  <= 1'b0;
        end else begin
            s1_q   <= i_pin;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
            if (s2_q == s3_q && s3_q != o_level) begin
                o_level <= s3_q;
                o_rise  <= s3_q;
                o_fall  <= ~s3_q;
            end
        end
    end
endmodule

// *** smoke_asic_program_port.v ***
// Factory programming, baseline and limit verification port of the smoke controller.
// ----------------------------------------------------------------------------
// Notes on behaviour
// - Eight mode step pulses while enabled select serial access mode.
// - In serial mode mode step is data and step clock shifts it.
// - A 58-bit shift register holds limits, baseline and options; fixture sends 58.
// - Serial mode shows shift register output on horn drive A.
// - Ten interconnect pulses, 5 ms wide, 10 ms period, commit the word.
// - After commit horn drive B flags alarm max <= normal or hysteresis >= normal.
// - Nine mode step pulses while enabled select baseline measurement mode.
// - A step clock pulse of at least 2 ms takes one baseline measurement.
// - Ten interconnect pulses with step clock low store the measured baseline.
// - Ten mode step pulses while enabled select normal limit verification.
// - Each 2 ms step clock pulse checks smoke; horn A high above limit.
// - Further steps verify hysteresis, hush, chamber, then alarm max limits.
// - Standby schedules smoke test every 10.75 s and chamber test every 43 s.
// - Normal limit bits 35:30, hysteresis 29:24, alarm max 11:6.
// ----------------------------------------------------------------------------
`include "smoke_prog_regs.vh"
module smoke_asic_program_port #(
    parameter integer SMOKE_PERIOD_CYC   = `SMOKE_PERIOD_CYC,
    parameter [39:0]  CHAMBER_PERIOD_CYC = `CHAMBER_PERIOD_CYC,
    parameter integer CHECK_MIN_CYC      = `CHECK_MIN_CYC
) (
    input  wire        i_core_clk,
    input  wire        i_sys_rst,
    input  wire        i_program_enable,
    input  wire        i_mode_step,
    input  wire        i_step_clock,
    input  wire        i_interconnect,
    input  wire [5:0]  i_detect_level,
    output reg         o_horn_drive_a,
    output reg         o_horn_drive_b,
    output reg  [57:0] o_nv_word,
    output reg         o_smoke_test_due,
    output reg         o_chamber_test_due,
    output reg         o_check_start,
    output wire [4:0]  o_step_count
);
    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    wire en_lvl;
    wire step_lvl;
    wire step_fall;
    wire clk_lvl;
    wire clk_rise;
    wire clk_fall;
    wire ic_rise;
    wire ic_fall;

    pin_sync3 u_sync_en (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_pin(i_program_enable),
        .o_level(en_lvl), .o_rise(), .o_fall());
    // Steps count on the falling edge, so a first data bit that rises before the
    // first shift clock is not taken for a ninth step.
    pin_sync3 u_sync_step (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_pin(i_mode_step),
        .o_level(step_lvl), .o_rise(), .o_fall(step_fall));
    pin_sync3 u_sync_clk (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_pin(i_step_clock),
        .o_level(clk_lvl), .o_rise(clk_rise), .o_fall(clk_fall));
    pin_sync3 u_sync_ic (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_pin(i_interconnect),
        .o_level(), .o_rise(ic_rise), .o_fall(ic_fall));

    // Six-bit limit greater-than used by the sanity flag and checks.
    function above;
        input [5:0] a;
        input [5:0] b;
        begin
            above = (a > b);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Mode step counter
    // ------------------------------------------------------------------------
    reg  [4:0]  step_cnt_q;
    reg  [57:0] shift_q;
    reg  [5:0]  baseline_q;
    reg  [3:0]  ic_cnt_q;
    reg  [31:0] hi_cnt_q;
    reg  [31:0] smoke_cnt_q;
    reg  [39:0] chamber_cnt_q;
    reg  [5:0]  limit_sel;
    reg         serial_lock_q;

    // Last count of each standby period, cut to the width of its counter.
    localparam [31:0] SMOKE_LAST   = SMOKE_PERIOD_CYC - 32'h1;
    localparam [39:0] CHAMBER_LAST = CHAMBER_PERIOD_CYC - 40'h1;

    wire serial_access_mode    = (step_cnt_q == `STEP_SERIAL);
    wire baseline_measure_mode = (step_cnt_q == `STEP_BASELINE);
    wire verify_mode = (step_cnt_q >= `STEP_NORMAL) && (step_cnt_q <= `STEP_ALARM_MAX);
    wire long_pulse  = (hi_cnt_q >= CHECK_MIN_CYC);

    assign o_step_count = step_cnt_q;

    // Count stops once the last verify mode is reached, so extra steps cannot wrap.
    // A step counts only until serial mode has locked, so eight steps may still go on to nine.
    always @(posedge i_core_clk) begin
        if (i_sys_rst || !en_lvl) begin
            step_cnt_q <= 5'h00;
        end else if (step_fall && !serial_lock_q && step_cnt_q != `STEP_ALARM_MAX) begin
            step_cnt_q <= step_cnt_q + 5'h01;
        end
    end

    // The first shift clock edge in serial mode locks it, since data now rides on the
    // mode step pin and its pulses must no longer count as steps.
    always @(posedge i_core_clk) begin
        if (i_sys_rst || !en_lvl) begin
            serial_lock_q <= 1'b0;
        end else if (serial_access_mode && clk_rise) begin
            serial_lock_q <= 1'b1;
        end
    end

    // Select the stored limit that the present verify mode checks against.
    always @* begin
        case (step_cnt_q)
            5'h0A:   limit_sel = o_nv_word[`NORMAL_LIMIT_MSB:`NORMAL_LIMIT_LSB];
            5'h0B:   limit_sel = o_nv_word[`HYST_LIMIT_MSB:`HYST_LIMIT_LSB];
            5'h0C:   limit_sel = o_nv_word[`HUSH_LIMIT_MSB:`HUSH_LIMIT_LSB];
            5'h0D:   limit_sel = o_nv_word[`CHAMBER_LIMIT_MSB:`CHAMBER_LIMIT_LSB];
            5'h0E:   limit_sel = o_nv_word[`ALARM_MAX_MSB:`ALARM_MAX_LSB];
            default: limit_sel = 6'h00;
        endcase
    end

    // ------------------------------------------------------------------------
    // Serial shift register and step clock high-time
    // ------------------------------------------------------------------------
    // Shifting happens only in serial mode; the word is not touched elsewhere.
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            shift_q <= 58'h0;
        end else if (serial_access_mode && clk_rise) begin
            shift_q <= {shift_q[56:0], step_lvl};
        end
    end

    // High-time counter saturates so a held clock cannot wrap past the minimum.
    always @(posedge i_core_clk) begin
        if (i_sys_rst || !clk_lvl) begin
            hi_cnt_q <= 32'h0;
        end else if (!long_pulse) begin
            hi_cnt_q <= hi_cnt_q + 32'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Measurement, checks and commit
    // ------------------------------------------------------------------------
    // The falling edge of a long enough step clock pulse triggers the action.
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            baseline_q     <= 6'h00;
            ic_cnt_q       <= 4'h0;
            o_nv_word      <= 58'h0;
            o_horn_drive_a <= 1'b0;
            o_horn_drive_b <= 1'b0;
            o_check_start  <= 1'b0;
        end else begin
            o_check_start <= 1'b0;
            if (!en_lvl) begin
                ic_cnt_q <= 4'h0;
            end
            if (serial_access_mode) begin
                o_horn_drive_a <= shift_q[57];
            end else if (!verify_mode) begin
                o_horn_drive_a <= 1'b0;
            end
            if (baseline_measure_mode && clk_fall && long_pulse) begin
                baseline_q <= i_detect_level;
            end
            if (verify_mode && clk_fall && long_pulse) begin
                o_check_start  <= 1'b1;
                o_horn_drive_a <= above(i_detect_level, limit_sel);
            end
            // Commit pulses are counted on falling interconnect edges.
            if (en_lvl && ic_fall && (serial_access_mode || (baseline_measure_mode && !clk_lvl))) begin
                if (ic_cnt_q == `COMMIT_PULSES - 4'h1) begin
                    ic_cnt_q <= 4'h0;
                    if (serial_access_mode) begin
                        o_nv_word <= shift_q;
                        o_horn_drive_b <= !above(shift_q[`ALARM_MAX_MSB:`ALARM_MAX_LSB],
                                shift_q[`NORMAL_LIMIT_MSB:`NORMAL_LIMIT_LSB]) ||
                            !above(shift_q[`NORMAL_LIMIT_MSB:`NORMAL_LIMIT_LSB],
                                shift_q[`HYST_LIMIT_MSB:`HYST_LIMIT_LSB]);
                    end else begin
                        o_nv_word[`BASELINE_MSB:`BASELINE_LSB] <= baseline_q;
                    end
                end else begin
                    ic_cnt_q <= ic_cnt_q + 4'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Standby test scheduler
    // ------------------------------------------------------------------------
    // Runs only outside programming so factory tests are not disturbed.
    // The chamber counter is 40 bits wide because its period overflows 32 bits.
    // Both counters restart together, so each chamber test falls on a smoke test.
    always @(posedge i_core_clk) begin
        if (i_sys_rst || en_lvl) begin
            smoke_cnt_q        <= 32'h0;
            chamber_cnt_q      <= 40'h0;
            o_smoke_test_due   <= 1'b0;
            o_chamber_test_due <= 1'b0;
        end else begin
            o_smoke_test_due   <= (smoke_cnt_q == SMOKE_LAST);
            o_chamber_test_due <= (chamber_cnt_q == CHAMBER_LAST);
            smoke_cnt_q   <= (smoke_cnt_q == SMOKE_LAST) ? 32'h0 : smoke_cnt_q + 32'h1;
            chamber_cnt_q <= (chamber_cnt_q == CHAMBER_LAST) ? 40'h0
                           : chamber_cnt_q + 40'h1;
        end
    end
endmodule

// *** smoke_fixture.sv ***
// Behavioural model of the production fixture that drives the programming pins.
module smoke_fixture (
    input  wire  i_core_clk,
    output logic o_program_enable,
    output logic o_mode_step,
    output logic o_step_clock,
    output logic o_interconnect
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins idle low; the step clock stands still between frames.
    initial begin
        o_program_enable = 1'b0;
        o_mode_step      = 1'b0;
        o_step_clock     = 1'b0;
        o_interconnect   = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    task automatic set_enable(input logic v);
        o_program_enable <= v;
        hold(10);
    endtask
    task automatic pulse_step(input int n);
        repeat (n) begin
            o_mode_step <= 1'b1;
            hold(10);
            o_mode_step <= 1'b0;
            hold(10);
        end
    endtask
    task automatic clock_high(input int n);
        o_step_clock <= 1'b1;
        hold(n);
        o_step_clock <= 1'b0;
        hold(10);
    endtask
    // Data settles a few cycles ahead of the clock so the synchroniser sees it first.
    task automatic shift_word(input logic [57:0] w);
        for (int i = 57; i >= 0; i--) begin
            o_mode_step <= w[i];
            hold(4);
            clock_high(10);
        end
        o_mode_step <= 1'b0;
    endtask
    // Widths are scaled down, since the port only counts the pulses.
    task automatic commit(input int n);
        repeat (n) begin
            o_interconnect <= 1'b1;
            hold(10);
            o_interconnect <= 1'b0;
            hold(10);
        end
    endtask
endmodule

// *** smoke_prog_chk.sv ***
// Concurrent property checker for the programming port.
module smoke_prog_chk #(
    parameter integer SMOKE_PERIOD_CYC = 100
) (
    input wire        i_core_clk,
    input wire        i_sys_rst,
    input wire        i_program_enable,
    input wire        i_mode_step,
    input wire        i_step_clock,
    input wire        i_interconnect,
    input wire [5:0]  i_detect_level,
    input wire        o_horn_drive_a,
    input wire        o_horn_drive_b,
    input wire [57:0] o_nv_word,
    input wire        o_smoke_test_due,
    input wire        o_chamber_test_due,
    input wire        o_check_start,
    input wire [4:0]  o_step_count
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);
    // Gap since the last smoke pulse; trusted only once enable stayed low.
    reg [31:0] gap_q;
    reg        gap_ok_q;
    always @(posedge i_core_clk) begin
        if (i_sys_rst || i_program_enable) begin
            gap_q    <= 32'h0;
            gap_ok_q <= 1'b0;
        end else begin
            gap_q    <= o_smoke_test_due ? 32'h0 : gap_q + 32'h1;
            gap_ok_q <= gap_ok_q | o_smoke_test_due;
        end
    end
    // Set once the step clock is seen high in serial mode; from then the mode is locked.
    reg        clk_seen_q;
    always @(posedge i_core_clk) begin
        if (i_sys_rst || o_step_count != 5'h08) begin
            clk_seen_q <= 1'b0;
        end else if (i_step_clock) begin
            clk_seen_q <= 1'b1;
        end
    end
    sequence s_serial_commit;
        $changed(o_nv_word) && $past(o_step_count) == 5'h08;
    endsequence
    chk_count_clear: assert property (!i_program_enable [*8] |-> o_step_count == 5'h00)
        else $error("step count not cleared");
    chk_count_step: assert property ($changed(o_step_count) |->
        o_step_count == $past(o_step_count) + 5'h01 || o_step_count == 5'h00)
        else $error("step count jumped");
    chk_count_ceiling: assert property (o_step_count <= 5'h0E)
        else $error("step count above last mode");
    chk_serial_hold: assert property (clk_seen_q && o_step_count != 5'h00
        |-> o_step_count == 5'h08) else $error("serial mode left by step");
    chk_commit_mode: assert property ($changed(o_nv_word) |->
        $past(o_step_count) inside {5'h08, 5'h09}) else $error("commit outside mode");
    chk_flag_rule: assert property (s_serial_commit |-> o_horn_drive_b ==
        (o_nv_word[11:6] <= o_nv_word[35:30] || o_nv_word[29:24] >= o_nv_word[35:30]))
        else $error("limit flag wrong");
    chk_base_only: assert property ($changed(o_nv_word) && $past(o_step_count) == 5'h09
        |-> ((o_nv_word ^ $past(o_nv_word)) >> 6) == 58'h0) else $error("baseline store hit limits");
    chk_check_mode: assert property (o_check_start |-> o_step_count >= 5'h0A ##1 !o_check_start)
        else $error("check start misplaced");
    chk_standby_quiet: assert property (i_program_enable [*8] |->
        !o_smoke_test_due && !o_chamber_test_due) else $error("standby test while enabled");
    chk_smoke_gap: assert property (o_smoke_test_due && gap_ok_q |->
        gap_q == SMOKE_PERIOD_CYC - 1) else $error("smoke period wrong");
endmodule
bind smoke_asic_program_port smoke_prog_chk #(.SMOKE_PERIOD_CYC(SMOKE_PERIOD_CYC)) chk_inst (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_program_enable(i_program_enable),
    .i_mode_step(i_mode_step), .i_step_clock(i_step_clock), .i_interconnect(i_interconnect),
    .i_detect_level(i_detect_level), .o_horn_drive_a(o_horn_drive_a),
    .o_horn_drive_b(o_horn_drive_b), .o_nv_word(o_nv_word), .o_check_start(o_check_start),
    .o_smoke_test_due(o_smoke_test_due), .o_chamber_test_due(o_chamber_test_due),
    .o_step_count(o_step_count));

// *** smoke_prog_regs.vh ***
// Constants shared by the programming port: field positions, counts and timing.
`ifndef SMOKE_PROG_REGS_VH
`define SMOKE_PROG_REGS_VH
// ----------------------------------------------------------------------------
// Shift word and field layout
// ----------------------------------------------------------------------------
`define CFG_WORD_BITS       58
`define LIMIT_BITS          6
`define NORMAL_LIMIT_MSB    35
`define NORMAL_LIMIT_LSB    30
`define HYST_LIMIT_MSB      29
`define HYST_LIMIT_LSB      24
`define HUSH_LIMIT_MSB      23
`define HUSH_LIMIT_LSB      18
`define CHAMBER_LIMIT_MSB   17
`define CHAMBER_LIMIT_LSB   12
`define ALARM_MAX_MSB       11
`define ALARM_MAX_LSB       6
`define BASELINE_MSB        5
`define BASELINE_LSB        0
// ----------------------------------------------------------------------------
// Mode step counts and commit pulse count
// ----------------------------------------------------------------------------
`define STEP_SERIAL         5'h08
`define STEP_BASELINE       5'h09
`define STEP_NORMAL         5'h0A
`define STEP_ALARM_MAX      5'h0E
`define COMMIT_PULSES       4'hA
// ----------------------------------------------------------------------------
// Timing: clock in kHz, times in ms
// ----------------------------------------------------------------------------
`define CLK_KHZ             125000
`define CHECK_MIN_MS        2
`define CHECK_MIN_CYC       (`CHECK_MIN_MS * `CLK_KHZ)
`define SMOKE_PERIOD_MS     10750
`define CHAMBER_PERIOD_MS   43000
`define SMOKE_PERIOD_CYC    (`SMOKE_PERIOD_MS * `CLK_KHZ)
// The chamber period does not fit in 32 bits at this clock, so it is reckoned in 40.
`define CHAMBER_PERIOD_CYC  (40'h0 + `CHAMBER_PERIOD_MS * `CLK_KHZ)
`endif

// *** testbench.sv ***
// Self-checking bench: fixture model drives the port through its test modes.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_core_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [5:0]  i_detect_level = 6'h00;
    wire         i_program_enable;
    wire         i_mode_step;
    wire         i_step_clock;
    wire         i_interconnect;
    wire         o_horn_drive_a;
    wire         o_horn_drive_b;
    wire         o_smoke_test_due;
    wire         o_chamber_test_due;
    wire         o_check_start;
    wire  [57:0] o_nv_word;
    wire  [4:0]  o_step_count;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          n_check = 0;
    always #4 i_core_clk = ~i_core_clk;
    // Check pulses last one cycle, so they are counted as they pass.
    always @(posedge i_core_clk) begin
        if (o_check_start) begin
            n_check <= n_check + 1;
        end
    end
    // Short counts keep the standby timers and check pulses within a brief run.
    smoke_asic_program_port #(.SMOKE_PERIOD_CYC(100), .CHAMBER_PERIOD_CYC(400),
        .CHECK_MIN_CYC(20)) smoke_asic_program_port_inst (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_program_enable(i_program_enable),
        .i_mode_step(i_mode_step), .i_step_clock(i_step_clock), .i_interconnect(i_interconnect),
        .i_detect_level(i_detect_level), .o_horn_drive_a(o_horn_drive_a),
        .o_horn_drive_b(o_horn_drive_b), .o_nv_word(o_nv_word), .o_check_start(o_check_start),
        .o_smoke_test_due(o_smoke_test_due), .o_chamber_test_due(o_chamber_test_due),
        .o_step_count(o_step_count));
    smoke_fixture smoke_fixture_inst (.i_core_clk(i_core_clk),
        .o_program_enable(i_program_enable), .o_mode_step(i_mode_step),
        .o_step_clock(i_step_clock), .o_interconnect(i_interconnect));
    // Options are an arbitrary pattern; the baseline is loaded as zeros.
    function automatic logic [57:0] mk(input logic [5:0] n, h, a);
        return {22'h2A5A5A, n, h, 6'h0F, 6'h19, a, 6'h00};
    endfunction
    task automatic chk(input string name, input logic [57:0] exp, input logic [57:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        logic [57:0] w [3];
        logic        f [3];
        logic [57:0] prev;
        logic [5:0]  lim;
        int          sm;
        int          ch;
        w = '{mk(6'h14, 6'h0A, 6'h1E), mk(6'h14, 6'h0A, 6'h14), mk(6'h14, 6'h14, 6'h1E)};
        f = '{1'b0, 1'b1, 1'b1};
        prev = 58'h0;
        sm = 0;
        ch = 0;
        repeat (10) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        repeat (50) @(posedge i_core_clk);
        repeat (400) begin
            @(posedge i_core_clk);
            sm += o_smoke_test_due;
            ch += o_chamber_test_due;
        end
        chk("smoke_due_count", 58'h4, 58'(sm));
        chk("chamber_due_count", 58'h1, 58'(ch));
        smoke_fixture_inst.set_enable(1'b1);
        smoke_fixture_inst.pulse_step(8);
        chk("step_count", 58'h08, 58'(o_step_count));
        for (int k = 0; k < 3; k++) begin
            smoke_fixture_inst.shift_word(w[k]);
            chk("serial_out", 58'(w[k][57]), 58'(o_horn_drive_a));
            smoke_fixture_inst.commit(9);
            chk("nv_word_early", prev, o_nv_word);
            smoke_fixture_inst.commit(1);
            chk("nv_word", w[k], o_nv_word);
            chk("limit_flag", 58'(f[k]), 58'(o_horn_drive_b));
            prev = w[k];
        end
        smoke_fixture_inst.pulse_step(1);
        chk("serial_hold", 58'h08, 58'(o_step_count));
        smoke_fixture_inst.set_enable(1'b0);
        chk("count_clear", 58'h0, 58'(o_step_count));
        smoke_fixture_inst.set_enable(1'b1);
        smoke_fixture_inst.pulse_step(9);
        chk("step_count", 58'h09, 58'(o_step_count));
        i_detect_level <= 6'h07;
        smoke_fixture_inst.clock_high(40);
        smoke_fixture_inst.commit(10);
        chk("baseline", {w[2][57:6], 6'h07}, o_nv_word);
        smoke_fixture_inst.set_enable(1'b0);
        smoke_fixture_inst.set_enable(1'b1);
        smoke_fixture_inst.pulse_step(10);
        for (int m = 10; m <= 14; m++) begin
            lim = w[2][35 - 6 * (m - 10) -: 6];
            chk("verify_mode", 58'(m), 58'(o_step_count));
            i_detect_level <= lim + 6'h01;
            smoke_fixture_inst.clock_high(5);
            chk("short_pulse", 58'h0, 58'(o_horn_drive_a));
            smoke_fixture_inst.clock_high(40);
            chk("above_limit", 58'h1, 58'(o_horn_drive_a));
            i_detect_level <= lim;
            smoke_fixture_inst.clock_high(40);
            chk("at_limit", 58'h0, 58'(o_horn_drive_a));
            smoke_fixture_inst.pulse_step(1);
        end
        chk("step_ceiling", 58'h0E, 58'(o_step_count));
        chk("check_pulses", 58'h0A, 58'(n_check));
        print_verdict();
    end
    // The run needs well under ten thousand cycles; a hang is cut off long after.
    initial begin
        repeat (50000) @(posedge i_core_clk);
        n_mismatch++;
        print_verdict();
    end
endmodule
